// ==== design/gpio_pkg.sv ====
// Constants, offsets and carrier types of the two-port pin block.
// Assumes an APB master on the bus clock and pads that take the pad controls.
// Behaviour
// - An enabled shared peripheral takes the pin from the port logic.
// - Reset clears direction, slew, drive and pull bits; pins become inputs.
// - Direction bit enables the output and picks the data read source.
// - Input buffer always on, except for analog-owned pins.
// - Shared digital function drives the output; direction still picks read source.
// - Analog owner disables both buffers; input data reads return zero.
// - Analog wins over digital when both own one pin.
// - Pull enable turns pull on, forced off for driven or analog pins.
// - Slew limit acts only while the pin drives.
// - Drive select picks high or low strength for driving pins.
// - Low four pins of both ports are interrupt and wake sources.
// - Per-pin select enables each pin as interrupt source.
// - Per-port mode picks edge only or edge and level.
// - Polarity picks falling/low or rising/high.
// - Edges found by sampling every cycle: deasserted then asserted.
// - A pin asserted from the outset gives no edge.
// - Edge mode: edge sets flag, acknowledge clears, request when enabled.
// - Level mode: edge or asserted level sets flag; enable raises request.
// - Level mode: acknowledge clears only if all enabled pins deasserted.
// - Polarity zero gives pull-up, one gives pull-down for interrupt pins.
// - Flag ignores writes; acknowledge reads zero.
// - Pull-down only on interrupt pins with select and polarity set.
package gpio_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NPORTS = 2;
  localparam int PORT_W = 6;
  localparam int IRQ_W = 4;
  localparam int ADDR_W = 8;

  // ****************************************************************
  // Register offsets within one port, and port stride
  // ****************************************************************
  localparam logic [4:0] OFS_DATA = 5'h00;
  localparam logic [4:0] OFS_DIR = 5'h04;
  localparam logic [4:0] OFS_PULL = 5'h08;
  localparam logic [4:0] OFS_SLEW = 5'h0C;
  localparam logic [4:0] OFS_DRIVE = 5'h10;
  localparam logic [4:0] OFS_IRQ_SC = 5'h14;
  localparam logic [4:0] OFS_IRQ_SEL = 5'h18;
  localparam logic [4:0] OFS_IRQ_POL = 5'h1C;
  localparam logic [ADDR_W-1:0] PORT_STRIDE = 8'h20;

  // ****************************************************************
  // Status/control field positions and reset values
  // ****************************************************************
  localparam int SC_MOD_BIT = 0;
  localparam int SC_IE_BIT = 1;
  localparam int SC_ACK_BIT = 2;
  localparam int SC_FLAG_BIT = 3;
  localparam logic [PORT_W-1:0] RST_PINS = 6'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;

  // Pad controls of one port
  typedef struct packed {
    logic [PORT_W-1:0] oe;
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] ibe;
    logic [PORT_W-1:0] pull_on;
    logic [PORT_W-1:0] pull_down;
    logic [PORT_W-1:0] slew;
    logic [PORT_W-1:0] drive;
  } pad_type;

  // Claims of on-chip peripherals on one port
  typedef struct packed {
    logic [PORT_W-1:0] dig_en;
    logic [PORT_W-1:0] dig_oe;
    logic [PORT_W-1:0] dig_out;
    logic [PORT_W-1:0] ana_en;
  } share_type;

endpackage : gpio_pkg

// ==== design/gpio_with_pin_interrupts.sv ====
// Two general-purpose ports with pad control and a pin interrupt unit each.
// Assumes pads outside resolve pin levels; peripherals claim pins via share.
`timescale 1ns/10ps

module gpio_with_pin_interrupts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpio_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [gpio_pkg::NPORTS-1:0][gpio_pkg::PORT_W-1:0] pin_in,
  input wire gpio_pkg::share_type [gpio_pkg::NPORTS-1:0] share,
  output gpio_pkg::pad_type [gpio_pkg::NPORTS-1:0] pad,
  output logic [gpio_pkg::NPORTS-1:0][gpio_pkg::PORT_W-1:0] pin_level,
  output logic [gpio_pkg::NPORTS-1:0] irq_req
);

  localparam int W = gpio_pkg::PORT_W;
  localparam int NP = gpio_pkg::NPORTS;
  localparam int IW = gpio_pkg::IRQ_W;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [W-1:0] data_q [NP];
  logic [W-1:0] dir_q [NP];
  logic [W-1:0] pull_q [NP];
  logic [W-1:0] slew_q [NP];
  logic [W-1:0] drive_q [NP];
  logic [IW-1:0] sel_q [NP];
  logic [IW-1:0] pol_q [NP];
  logic [NP-1:0] mode_q;
  logic [NP-1:0] ie_q;
  logic [NP-1:0] flag_q;
  logic [IW-1:0] armed_q [NP];
  logic [W-1:0] sync1_q [NP];
  logic [W-1:0] sync2_q [NP];
  logic [W-1:0] sync3_q [NP];
  logic [W-1:0] lvl_q [NP];
  gpio_pkg::pad_type [NP-1:0] pad_q;
  logic [NP-1:0] irq_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  logic [IW-1:0] asserted [NP];
  logic [IW-1:0] edge_hit [NP];
  logic [NP-1:0] flag_set;
  logic [NP-1:0] any_asserted;
  logic [NP-1:0] ack;
  gpio_pkg::pad_type [NP-1:0] pad_d;
  logic [W-1:0] read_data [NP];

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic port_idx;
  logic [4:0] reg_ofs;
  logic mapped;
  logic wr_en;

  assign port_idx = paddr[5];
  assign reg_ofs = paddr[4:0];
  // Upper address bits and misaligned words fall outside the map
  assign mapped = (paddr[gpio_pkg::ADDR_W-1:6] == 2'h0) && (paddr[1:0] == 2'h0);
  // Writes land only at the completing access edge
  assign wr_en = psel && penable && pready_q && pwrite && mapped;

  // ****************************************************************
  // Pin input synchronisers and level filter
  // ****************************************************************
  // Level changes only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) begin
        sync1_q[p] <= gpio_pkg::RST_PINS;
        sync2_q[p] <= gpio_pkg::RST_PINS;
        sync3_q[p] <= gpio_pkg::RST_PINS;
        lvl_q[p] <= gpio_pkg::RST_PINS;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        sync1_q[p] <= pin_in[p];
        sync2_q[p] <= sync1_q[p];
        sync3_q[p] <= sync2_q[p];
        for (int b = 0; b < W; b++) begin
          if (sync2_q[p][b] == sync3_q[p][b]) begin
            lvl_q[p][b] <= sync3_q[p][b];
          end
        end
      end
    end
  end

  // ****************************************************************
  // Pad control and read source
  // ****************************************************************
  // Analog beats digital, digital beats the port itself
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      logic [W-1:0] ana;
      logic [W-1:0] dig;
      logic [W-1:0] drv;
      logic [W-1:0] pol_ext;
      logic [W-1:0] sel_ext;
      ana = share[p].ana_en;
      dig = share[p].dig_en & ~ana;
      pol_ext = {{(W-IW){1'b0}}, pol_q[p]};
      sel_ext = {{(W-IW){1'b0}}, sel_q[p]};
      // Owner decides whether the pin is driven
      drv = ((dig & share[p].dig_oe) | (~dig & ~ana & dir_q[p])) & ~ana;
      pad_d[p].oe = drv;
      pad_d[p].out = (dig & share[p].dig_out) | (~dig & data_q[p]);
      pad_d[p].ibe = ~ana;
      pad_d[p].pull_on = pull_q[p] & ~drv & ~ana;
      // Pull-down only for interrupt pins with rising/high polarity
      pad_d[p].pull_down = pull_q[p] & ~drv & ~ana & sel_ext & pol_ext;
      pad_d[p].slew = slew_q[p] & drv;
      pad_d[p].drive = drive_q[p] & drv;
      // Direction picks latch or pin; disabled input buffer reads zero
      read_data[p] = (dir_q[p] & data_q[p]) | (~dir_q[p] & ~ana & lvl_q[p]);
    end
  end

  // Pads registered so outputs come straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_q <= '0;
    end else begin
      pad_q <= pad_d;
    end
  end

  // ****************************************************************
  // Port configuration registers
  // ****************************************************************
  // Output latch; its reset zeros are not driven until direction is set, pins start as inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) begin
        data_q[p] <= gpio_pkg::RST_PINS;
      end
    end else if (wr_en && (reg_ofs == gpio_pkg::OFS_DATA)) begin
      data_q[port_idx] <= pwdata[W-1:0];
    end
  end

  // Direction; cleared so a pin never drives the board out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) begin
        dir_q[p] <= gpio_pkg::RST_PINS;
      end
    end else if (wr_en && (reg_ofs == gpio_pkg::OFS_DIR)) begin
      dir_q[port_idx] <= pwdata[W-1:0];
    end
  end

  // Pull enable; pad logic still forces it off for driven pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) begin
        pull_q[p] <= gpio_pkg::RST_PINS;
      end
    end else if (wr_en && (reg_ofs == gpio_pkg::OFS_PULL)) begin
      pull_q[port_idx] <= pwdata[W-1:0];
    end
  end

  // Slew limit; kept but inert while the pin is an input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) begin
        slew_q[p] <= gpio_pkg::RST_PINS;
      end
    end else if (wr_en && (reg_ofs == gpio_pkg::OFS_SLEW)) begin
      slew_q[port_idx] <= pwdata[W-1:0];
    end
  end

  // Drive strength; kept but inert while the pin is an input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) begin
        drive_q[p] <= gpio_pkg::RST_PINS;
      end
    end else if (wr_en && (reg_ofs == gpio_pkg::OFS_DRIVE)) begin
      drive_q[port_idx] <= pwdata[W-1:0];
    end
  end

  // Interrupt pin select, low four pins only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) begin
        sel_q[p] <= gpio_pkg::RST_IRQ;
      end
    end else if (wr_en && (reg_ofs == gpio_pkg::OFS_IRQ_SEL)) begin
      sel_q[port_idx] <= pwdata[IW-1:0];
    end
  end

  // Polarity; also picks pull-up or pull-down on interrupt pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) begin
        pol_q[p] <= gpio_pkg::RST_IRQ;
      end
    end else if (wr_en && (reg_ofs == gpio_pkg::OFS_IRQ_POL)) begin
      pol_q[port_idx] <= pwdata[IW-1:0];
    end
  end

  // Mode and request enable; flag and acknowledge are handled apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= '0;
      ie_q <= '0;
    end else if (wr_en && (reg_ofs == gpio_pkg::OFS_IRQ_SC)) begin
      mode_q[port_idx] <= pwdata[gpio_pkg::SC_MOD_BIT];
      ie_q[port_idx] <= pwdata[gpio_pkg::SC_IE_BIT];
    end
  end

  // ****************************************************************
  // Pin interrupt detection
  // ****************************************************************
  // Asserted level: low for polarity 0, high for polarity 1
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      asserted[p] = ~(lvl_q[p][IW-1:0] ^ pol_q[p]);
      // Edge needs a deasserted sample in the previous cycle
      edge_hit[p] = sel_q[p] & armed_q[p] & asserted[p];
      any_asserted[p] = |(sel_q[p] & asserted[p]);
      flag_set[p] = (|edge_hit[p]) || (mode_q[p] && any_asserted[p]);
      ack[p] = wr_en && (reg_ofs == gpio_pkg::OFS_IRQ_SC) && (port_idx == 1'(p))
               && pwdata[gpio_pkg::SC_ACK_BIT];
    end
  end

  // Armed only after an enabled pin was seen deasserted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NP; p++) begin
        armed_q[p] <= gpio_pkg::RST_IRQ;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        armed_q[p] <= sel_q[p] & ~asserted[p];
      end
    end
  end

  // Flag: set beats acknowledge; level mode holds while any pin asserted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (flag_set[p]) begin
          flag_q[p] <= 1'b1;
        end else if (ack[p] && !(mode_q[p] && any_asserted[p])) begin
          flag_q[p] <= 1'b0;
        end
      end
    end
  end

  // Request doubles as the wake-up line for low-power modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= '0;
    end else begin
      irq_q <= flag_q & ie_q;
    end
  end

  // ****************************************************************
  // APB read path and answer
  // ****************************************************************
  // Answer one cycle after setup; no wait states, so no stall counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !mapped;
    end
  end

  // Read data captured in the setup cycle; access phase takes one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else begin
      if (psel && !penable && !pwrite && mapped) begin
        prdata_q <= 32'h00000000;
        unique case (reg_ofs)
          gpio_pkg::OFS_DATA: prdata_q[W-1:0] <= read_data[port_idx];
          gpio_pkg::OFS_DIR: prdata_q[W-1:0] <= dir_q[port_idx];
          gpio_pkg::OFS_PULL: prdata_q[W-1:0] <= pull_q[port_idx];
          gpio_pkg::OFS_SLEW: prdata_q[W-1:0] <= slew_q[port_idx];
          gpio_pkg::OFS_DRIVE: prdata_q[W-1:0] <= drive_q[port_idx];
          gpio_pkg::OFS_IRQ_SEL: prdata_q[IW-1:0] <= sel_q[port_idx];
          gpio_pkg::OFS_IRQ_POL: prdata_q[IW-1:0] <= pol_q[port_idx];
          // Acknowledge bit always reads zero; flag is read-only
          gpio_pkg::OFS_IRQ_SC: begin
            prdata_q[gpio_pkg::SC_FLAG_BIT] <= flag_q[port_idx];
            prdata_q[gpio_pkg::SC_IE_BIT] <= ie_q[port_idx];
            prdata_q[gpio_pkg::SC_MOD_BIT] <= mode_q[port_idx];
          end
          default: begin
          end
        endcase
      end else if (psel && !penable) begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pad = pad_q;
  assign irq_req = irq_q;

  // Filtered pin levels for the peripherals sharing the pins
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      pin_level[p] = lvl_q[p];
    end
  end

endmodule : gpio_with_pin_interrupts

// ==== test/gpio_irq_asserts.sv ====
// Checker for pad routing and port A interrupts of the two-port pin block.
// Sees only top ports; keeps a shadow of port A setup from APB writes.
`timescale 1ns/10ps
module gpio_irq_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpio_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire gpio_pkg::share_type [gpio_pkg::NPORTS-1:0] share,
  input wire gpio_pkg::pad_type [gpio_pkg::NPORTS-1:0] pad,
  input wire logic [gpio_pkg::NPORTS-1:0][gpio_pkg::PORT_W-1:0] pin_level,
  input wire logic [gpio_pkg::NPORTS-1:0] irq_req
);
  // ************
  // Shadow state
  // ************
  logic wr, ack_w, mode_q, ie_q;
  logic [5:0] dir_q, pe_q, oe_c, pull_c, ana_c;
  logic [3:0] sel_q, pol_q, pd_c;
  assign wr = psel && penable && pready && pwrite;
  assign ack_w = wr && paddr == 8'h14 && pwdata[2];
  // Analog first, then digital owner, then port
  assign ana_c = share[0].ana_en;
  assign oe_c = ~ana_c & (share[0].dig_en & share[0].dig_oe | ~share[0].dig_en & dir_q);
  assign pull_c = pe_q & ~oe_c & ~ana_c;
  assign pd_c = sel_q & pol_q;
  // Taken at the same edge as the design takes the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {dir_q, pe_q, sel_q, pol_q, mode_q, ie_q} <= '0;
    end else if (wr) begin
      case (paddr)
        8'h04: dir_q <= pwdata[5:0];
        8'h08: pe_q <= pwdata[5:0];
        8'h14: {ie_q, mode_q} <= pwdata[1:0];
        8'h18: sel_q <= pwdata[3:0];
        8'h1C: pol_q <= pwdata[3:0];
        default: ;
      endcase
    end
  end
  // ************
  // Properties
  // ************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Acknowledge with pins quiet over two samples
  sequence ack_quiet;
    !mode_q && ack_w && $stable(pin_level[0]) ##1 $stable(pin_level[0]);
  endsequence
  // Some enabled pin held at its asserted level
  sequence lvl_held;
    (mode_q && ie_q && |(sel_q & ~(pin_level[0][3:0] ^ pol_q))) [*3];
  endsequence
  a_oe_route: assert property ($past(presetn) |-> pad[0].oe == $past(oe_c))
    else $error("output enable routing wrong");
  a_ibe_analog: assert property ($past(presetn) |-> pad[0].ibe == ~$past(ana_c))
    else $error("input buffer enable wrong");
  a_pull_off: assert property ($past(presetn) |-> pad[0].pull_on == $past(pull_c))
    else $error("pull enable wrong");
  a_pull_down: assert property ($past(presetn) |->
    pad[0].pull_down == {2'b00, pad[0].pull_on[3:0] & $past(pd_c)})
    else $error("pull down select wrong");
  a_edge_req: assert property (!mode_q && ie_q && sel_q[0] && pol_q[0]
    && $past(sel_q[0]) && $past(pol_q[0]) && $rose(pin_level[0][0]) |-> ##2 irq_req[0])
    else $error("edge gave no request");
  a_req_gate: assert property (irq_req[0] |-> $past(ie_q))
    else $error("request without enable");
  a_ack_clear: assert property (ack_quiet |=> !irq_req[0])
    else $error("acknowledge did not clear");
  a_level_hold: assert property (lvl_held |-> irq_req[0])
    else $error("asserted level lost request");
endmodule : gpio_irq_asserts

bind gpio_with_pin_interrupts gpio_irq_asserts chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .share, .pad, .pin_level, .irq_req);

// ==== test/pin_board.sv ====
// Board model for both ports: pads, bench drivers and pull devices.
// Assumes the bench clock; a line nobody holds toggles every cycle.
`timescale 1ns/10ps
module pin_board (
  input wire logic pclk,
  input wire gpio_pkg::pad_type [gpio_pkg::NPORTS-1:0] pad,
  input wire logic [gpio_pkg::NPORTS-1:0][gpio_pkg::PORT_W-1:0] ext_val,
  input wire logic [gpio_pkg::NPORTS-1:0][gpio_pkg::PORT_W-1:0] ext_drv,
  output logic [gpio_pkg::NPORTS-1:0][gpio_pkg::PORT_W-1:0] pin_in
);
  // ************
  // Pin levels
  // ************
  logic flt_q = 1'b0;
  // Floating lines must not look stable
  always @(posedge pclk) begin
    flt_q <= ~flt_q;
  end
  // Pad drive wins, then the board, then the pull device
  always_comb begin
    for (int p = 0; p < gpio_pkg::NPORTS; p++) begin
      for (int b = 0; b < gpio_pkg::PORT_W; b++) begin
        if (pad[p].oe[b]) pin_in[p][b] = pad[p].out[b];
        else if (ext_drv[p][b]) pin_in[p][b] = ext_val[p][b];
        else if (pad[p].pull_on[b]) pin_in[p][b] = ~pad[p].pull_down[b];
        else pin_in[p][b] = flt_q;
      end
    end
  end
endmodule : pin_board

// ==== test/test_gpio_with_pin_interrupts.sv ====
// Self-checking bench for the two-port pin block with interrupts.
// Assumes the board model on the pins and the bound checker.
`timescale 1ns/10ps
module test_gpio_with_pin_interrupts;
  // ************
  // Signals
  // ************
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, t, seed = 32'h516AB6E2;
  logic [1:0][5:0] pin_in, pin_level, ev = '0, ed = '1;
  logic [5:0] d, r;
  logic [1:0] irq_req;
  gpio_pkg::share_type [1:0] share = '0;
  gpio_pkg::pad_type [1:0] pad;
  int fail_count = 0, n_compared = 0, cyc = 0;
  gpio_with_pin_interrupts dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin_in, .share, .pad, .pin_level, .irq_req);
  pin_board board (.pclk, .pad, .ext_val(ev), .ext_drv(ed), .pin_in);
  always #2 pclk = ~pclk;
  // Hang guard, far above the run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // One APB transfer; holds everything until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // ************
  // Scenarios
  // ************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 64; i += 4) begin
      apb(0, 8'(i), 0);
      chk("reset value", 0, rd);
      chk("mapped err", 0, 32'(err));
    end
    $display("end reset values");
    // Data loaded before direction, random pins underneath
    for (int k = 0; k < 8; k++) begin
      t = rnd();
      {r, d} = t[11:0];
      ev[1] <= t[17:12];
      apb(1, 8'h20, 32'(d));
      apb(1, 8'h24, 32'(r));
      apb(1, 8'h30, 32'(t[23:18]));
      apb(1, 8'h2C, 32'(t[29:24]));
      repeat (6) @(posedge pclk);
      apb(0, 8'h20, 0);
      chk("data read", 32'(d & r | ev[1] & ~r), rd);
      chk("pad oe", 32'(r), 32'(pad[1].oe));
      chk("pad drive", 32'(t[23:18] & r), 32'(pad[1].drive));
      chk("pad slew", 32'(t[29:24] & r), 32'(pad[1].slew));
      chk("pin level", 32'(d & r | ev[1] & ~r), 32'(pin_level[1]));
      apb(0, 8'h30, 0);
      chk("drive reg", 32'(t[23:18]), rd);
    end
    $display("end data and direction");
    apb(1, 8'h24, 0);
    apb(1, 8'h28, 32'h3F);
    share[1] <= {6'h03, 6'h01, 6'h01, 6'h02};
    ev[1] <= 6'h3F;
    repeat (6) @(posedge pclk);
    apb(0, 8'h20, 0);
    chk("shared read", 32'h3D, rd);
    chk("shared oe", 32'h01, 32'(pad[1].oe));
    chk("shared ibe", 32'h3D, 32'(pad[1].ibe));
    chk("shared pull", 32'h3C, 32'(pad[1].pull_on));
    share[1] <= '0;
    apb(0, 8'hC0, 0);
    chk("unmapped err", 1, 32'(err));
    chk("unmapped read", 0, rd);
    $display("end sharing and unmapped");
    // Interrupt setup in the safe order, edge mode on bit 0
    foreach (t[i]) if (i < 6) apb(1, {3'h0, 5'(i) << 2}, 32'({28'h0, 4'h0}));
    apb(1, 8'h1C, 1);
    apb(1, 8'h08, 1);
    apb(1, 8'h18, 1);
    apb(1, 8'h14, 4);
    apb(1, 8'h14, 2);
    chk("pull down", 1, 32'(pad[0].pull_down));
    ev[0] <= 6'h01;
    repeat (8) @(posedge pclk);
    chk("edge request", 1, 32'(irq_req[0]));
    apb(1, 8'h14, 2);
    apb(0, 8'h14, 0);
    chk("flag kept", 32'h0A, rd);
    apb(1, 8'h14, 6);
    repeat (3) @(posedge pclk);
    chk("ack request", 0, 32'(irq_req[0]));
    apb(1, 8'h14, 32'h0A);
    apb(0, 8'h14, 0);
    chk("flag write", 32'h02, rd);
    apb(1, 8'h14, 0);
    ev[0] <= 6'h00;
    repeat (8) @(posedge pclk);
    ev[0] <= 6'h01;
    repeat (8) @(posedge pclk);
    chk("masked", 0, 32'(irq_req[0]));
    apb(0, 8'h14, 0);
    chk("masked flag", 32'h08, rd);
    apb(1, 8'h14, 4);
    apb(1, 8'h18, 0);
    ev[0] <= 6'h00;
    repeat (8) @(posedge pclk);
    ev[0] <= 6'h01;
    repeat (8) @(posedge pclk);
    apb(0, 8'h14, 0);
    chk("deselected", 0, rd);
    apb(1, 8'h18, 1);
    repeat (8) @(posedge pclk);
    apb(0, 8'h14, 0);
    chk("asserted first", 0, rd);
    $display("end edge mode");
    // Level mode, low level on bit 1
    ev[0] <= 6'h03;
    apb(1, 8'h1C, 0);
    apb(1, 8'h18, 2);
    apb(1, 8'h14, 4);
    apb(1, 8'h14, 3);
    ev[0] <= 6'h01;
    repeat (8) @(posedge pclk);
    chk("level request", 1, 32'(irq_req[0]));
    apb(1, 8'h14, 7);
    repeat (3) @(posedge pclk);
    apb(0, 8'h14, 0);
    chk("level held", 32'h0B, rd);
    ev[0] <= 6'h03;
    repeat (8) @(posedge pclk);
    apb(1, 8'h14, 7);
    repeat (3) @(posedge pclk);
    apb(0, 8'h14, 0);
    chk("level cleared", 32'h03, rd);
    chk("level idle", 0, 32'(irq_req[0]));
    chk("port b idle", 0, 32'(irq_req[1]));
    $display("end level mode");
    stop_test();
  end
endmodule : test_gpio_with_pin_interrupts
